// ==== hw/gdc_pkg.sv ====
package gdc_pkg;

    // Clock and interval unit; the unit count follows from the clock rate
    localparam int CLK_HZ = 200_000_000;
    localparam int UNIT_NS = 2000;
    localparam int UNIT_CYC = (UNIT_NS * (CLK_HZ / 1_000_000)) / 1000;

    // Bus geometry: byte address, register index is the word number
    localparam int ADDR_W = 9;
    localparam int IDX_W = 7;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_OSC_OVR = 7'h40;
    localparam logic [IDX_W-1:0] IDX_OSC_PER = 7'h41;
    localparam logic [IDX_W-1:0] IDX_CRS_OVR = 7'h42;
    localparam logic [IDX_W-1:0] IDX_FIN_OVR = 7'h43;
    localparam logic [IDX_W-1:0] IDX_AMP_PER = 7'h44;
    localparam logic [IDX_W-1:0] IDX_OSC_STAT = 7'h50;
    localparam logic [IDX_W-1:0] IDX_AMP_STAT = 7'h51;

    // Field layout
    localparam int FORCE_BIT = 15;
    localparam int OSC_CODE_W = 8;
    localparam int AMP_CODE_W = 6;
    localparam int RANGE_W = 2;
    localparam int STEP_W = 6;
    localparam int STAT_FORCE_BIT = 8;
    localparam int STAT_FINE_LSB = 8;

    // Implemented bits of the override registers; the rest read zero
    localparam logic [REG_W-1:0] OSC_OVR_MASK = 16'h80ff;
    localparam logic [REG_W-1:0] AMP_OVR_MASK = 16'h803f;

    // Reset values
    localparam logic [REG_W-1:0] OVR_RST = 16'h0000;
    localparam logic [REG_W-1:0] PER_RST = 16'h01f4;
    localparam logic [REG_W-1:0] PER_ZERO = 16'h0000;
    localparam logic [REG_W-1:0] PER_ONE = 16'h0001;

    // Oscillator drive code as handed to the analog drive
    typedef struct packed {
        logic [RANGE_W-1:0] range_sel;
        logic [STEP_W-1:0] step;
    } gdc_osc_code_t;

endpackage

// ==== hw/gdc_gain_ctrl.sv ====
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
// What this block does
// - Oscillator force bit set: drive forced code, stop automatic oscillator updates.
// - Oscillator code refreshes once every period times 2 us.
// - Oscillator period zero: no automatic oscillator code updates; a set force bit still applies the forced code.
// - One 2 us interval unit is a fixed count of system clocks.
// - Coarse force bit set: apply forced coarse code, stop automatic coarse updates.
// - Fine force bit set: apply forced fine code, stop automatic fine updates.
// - Coarse and fine share one period; each refreshes every period times 2 us.
// - Shared amplifier period zero: neither coarse nor fine code updates.
// - Oscillator code leaves as 2-bit range select and 6-bit step.
module gdc_gain_ctrl
    import gdc_pkg::*;
#(
    parameter int UNIT_CYC_P = UNIT_CYC
) (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [DATA_W-1:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [DATA_W-1:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    input wire gdc_osc_code_t OSC_AUTO_CODE_I,
    input wire logic [AMP_CODE_W-1:0] COARSE_AUTO_CODE_I,
    input wire logic [AMP_CODE_W-1:0] FINE_AUTO_CODE_I,
    output gdc_osc_code_t OSC_CODE_O,
    output logic [AMP_CODE_W-1:0] COARSE_CODE_O,
    output logic [AMP_CODE_W-1:0] FINE_CODE_O,
    output logic OSC_UPDATE_O,
    output logic COARSE_UPDATE_O,
    output logic FINE_UPDATE_O
);

    localparam int NCTL = 3;
    localparam int PRE_W = $clog2(UNIT_CYC_P);
    localparam logic [PRE_W-1:0] PRE_MAX = PRE_W'(UNIT_CYC_P - 1);
    localparam logic [PRE_W-1:0] PRE_ZERO = '0;
    localparam logic [PRE_W-1:0] PRE_ONE = PRE_W'(1);

    // Byte-lane merge; only lanes 0 and 1 carry register bits
    function automatic logic [REG_W-1:0] be_merge(input logic [REG_W-1:0] old_v,
                                                 input logic [DATA_W-1:0] wd,
                                                 input logic [3:0] be);
        be_merge = {be[1] ? wd[15:8] : old_v[15:8], be[0] ? wd[7:0] : old_v[7:0]};
    endfunction

    logic wait_q;
    logic [DATA_W-1:0] rdata_q;
    logic [REG_W-1:0] osc_ovr_q;
    logic [REG_W-1:0] osc_per_q;
    logic [REG_W-1:0] crs_ovr_q;
    logic [REG_W-1:0] fin_ovr_q;
    logic [REG_W-1:0] amp_per_q;
    gdc_osc_code_t osc_code_q;
    logic [AMP_CODE_W-1:0] crs_code_q;
    logic [AMP_CODE_W-1:0] fin_code_q;
    logic [NCTL-1:0] upd_q;
    logic [PRE_W-1:0] pre_q [NCTL];
    logic [REG_W-1:0] cnt_q [NCTL];

    // Bus decode: a request is accepted in the cycle where waitrequest is low
    wire logic req = AVS_READ_I | AVS_WRITE_I;
    wire logic acc = req & ~wait_q;
    wire logic wr_acc = AVS_WRITE_I & ~wait_q;
    wire logic [IDX_W-1:0] idx = AVS_ADDRESS_I[ADDR_W-1:2];
    wire logic hit_osc_ovr = idx == IDX_OSC_OVR;
    wire logic hit_osc_per = idx == IDX_OSC_PER;
    wire logic hit_crs_ovr = idx == IDX_CRS_OVR;
    wire logic hit_fin_ovr = idx == IDX_FIN_OVR;
    wire logic hit_amp_per = idx == IDX_AMP_PER;
    wire logic hit_osc_st = idx == IDX_OSC_STAT;
    wire logic hit_amp_st = idx == IDX_AMP_STAT;
    wire logic wait_d = acc | ~req;

    // Next register values; reserved override bits are masked on the way in
    wire logic [REG_W-1:0] osc_ovr_d = be_merge(osc_ovr_q, AVS_WRITEDATA_I,
                                                AVS_BYTEENABLE_I) & OSC_OVR_MASK;
    wire logic [REG_W-1:0] crs_ovr_d = be_merge(crs_ovr_q, AVS_WRITEDATA_I,
                                                AVS_BYTEENABLE_I) & AMP_OVR_MASK;
    wire logic [REG_W-1:0] fin_ovr_d = be_merge(fin_ovr_q, AVS_WRITEDATA_I,
                                                AVS_BYTEENABLE_I) & AMP_OVR_MASK;
    wire logic [REG_W-1:0] osc_per_d = be_merge(osc_per_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
    wire logic [REG_W-1:0] amp_per_d = be_merge(amp_per_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);

    // Status words show what is really applied to the analog side
    wire logic [REG_W-1:0] osc_stat = {7'h00, osc_ovr_q[FORCE_BIT], osc_code_q};
    wire logic [REG_W-1:0] amp_stat = {2'h0, fin_code_q, 2'h0, crs_code_q};

    // Read mux; unmapped indices read zero
    wire logic [REG_W-1:0] rd_word =
        hit_osc_ovr ? osc_ovr_q :
        hit_osc_per ? osc_per_q :
        hit_crs_ovr ? crs_ovr_q :
        hit_fin_ovr ? fin_ovr_q :
        hit_amp_per ? amp_per_q :
        hit_osc_st ? osc_stat :
        hit_amp_st ? amp_stat : 16'h0000;

    // Bus handshake: one wait cycle, read data captured ahead of the ack edge
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            wait_q <= 1'b1;
            rdata_q <= '0;
        end else begin
            wait_q <= wait_d;
            if (AVS_READ_I && wait_q) begin
                rdata_q <= {16'h0000, rd_word};
            end
        end
    end

    // Register writes take effect at the edge where waitrequest is seen low
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            osc_ovr_q <= OVR_RST;
            osc_per_q <= PER_RST;
            crs_ovr_q <= OVR_RST;
            fin_ovr_q <= OVR_RST;
            amp_per_q <= PER_RST;
        end else if (wr_acc) begin
            if (hit_osc_ovr) osc_ovr_q <= osc_ovr_d;
            if (hit_osc_per) osc_per_q <= osc_per_d;
            if (hit_crs_ovr) crs_ovr_q <= crs_ovr_d;
            if (hit_fin_ovr) fin_ovr_q <= fin_ovr_d;
            if (hit_amp_per) amp_per_q <= amp_per_d;
        end
    end

    // Per-controller view: coarse and fine share one period but keep own counters
    logic [REG_W-1:0] period [NCTL];
    logic [NCTL-1:0] force_en;
    logic [NCTL-1:0] restart;
    logic [NCTL-1:0] hold;
    logic [NCTL-1:0] unit_tick;
    logic [NCTL-1:0] upd;
    assign period[0] = osc_per_q;
    assign period[1] = amp_per_q;
    assign period[2] = amp_per_q;
    assign force_en = {fin_ovr_q[FORCE_BIT], crs_ovr_q[FORCE_BIT], osc_ovr_q[FORCE_BIT]};
    // A period write restarts the interval so a shorter period never overshoots
    assign restart = {{2{wr_acc & hit_amp_per}}, wr_acc & hit_osc_per};

    // Interval timers: a prescaler makes the 2 us unit, a counter counts units
    for (genvar i = 0; i < NCTL; i++) begin : g_tmr
        assign hold[i] = force_en[i] | (period[i] == PER_ZERO) | restart[i];
        assign unit_tick[i] = ~hold[i] & (pre_q[i] == PRE_MAX);
        assign upd[i] = unit_tick[i] & (cnt_q[i] == period[i] - PER_ONE);

        always_ff @(posedge CLK_I) begin
            if (SYS_RST_I || hold[i]) begin
                pre_q[i] <= PRE_ZERO;
                cnt_q[i] <= PER_ZERO;
            end else begin
                pre_q[i] <= (pre_q[i] == PRE_MAX) ? PRE_ZERO : pre_q[i] + PRE_ONE;
                if (unit_tick[i]) begin
                    cnt_q[i] <= upd[i] ? PER_ZERO : cnt_q[i] + PER_ONE;
                end
            end
        end
    end

    // Applied codes: a forced code wins; otherwise the automatic code at each refresh
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            osc_code_q <= '0;
            crs_code_q <= '0;
            fin_code_q <= '0;
            upd_q <= '0;
        end else begin
            upd_q <= upd;
            if (force_en[0]) begin
                osc_code_q <= osc_ovr_q[OSC_CODE_W-1:0];
            end else if (upd[0]) begin
                osc_code_q <= OSC_AUTO_CODE_I;
            end
            if (force_en[1]) begin
                crs_code_q <= crs_ovr_q[AMP_CODE_W-1:0];
            end else if (upd[1]) begin
                crs_code_q <= COARSE_AUTO_CODE_I;
            end
            if (force_en[2]) begin
                fin_code_q <= fin_ovr_q[AMP_CODE_W-1:0];
            end else if (upd[2]) begin
                fin_code_q <= FINE_AUTO_CODE_I;
            end
        end
    end

    assign AVS_READDATA_O = rdata_q;
    assign AVS_WAITREQUEST_O = wait_q;
    assign OSC_CODE_O = osc_code_q;
    assign COARSE_CODE_O = crs_code_q;
    assign FINE_CODE_O = fin_code_q;
    assign OSC_UPDATE_O = upd_q[0];
    assign COARSE_UPDATE_O = upd_q[1];
    assign FINE_UPDATE_O = upd_q[2];

    // Checking helpers: cycles since the last refresh or hold of each timer
    logic [31:0] gap_q [NCTL];
    for (genvar i = 0; i < NCTL; i++) begin : g_gap
        always_ff @(posedge CLK_I) begin
            if (SYS_RST_I || hold[i] || upd[i]) begin
                gap_q[i] <= '0;
            end else begin
                gap_q[i] <= gap_q[i] + 32'h00000001;
            end
        end
    end

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    // Forced oscillator code reaches the drive one edge later
    osc_force_a: assert property (
        osc_ovr_q[FORCE_BIT] |=> (OSC_CODE_O == $past(osc_ovr_q[OSC_CODE_W-1:0]))
            && !OSC_UPDATE_O)
        else $error("forced oscillator code not applied");

    osc_period_a: assert property (
        upd[0] |-> gap_q[0] == 32'(osc_per_q) * 32'(UNIT_CYC_P) - 32'h00000001)
        else $error("oscillator refresh interval wrong");

    // A force while the period is zero may change the code legally, so it is excluded
    osc_zero_a: assert property (
        (osc_per_q == PER_ZERO && !osc_ovr_q[FORCE_BIT]) [*2]
            |=> !OSC_UPDATE_O && $stable(OSC_CODE_O))
        else $error("oscillator updated with zero period");

    unit_count_a: assert property (
        (!hold[0] && pre_q[0] != PRE_MAX) |=> pre_q[0] == $past(pre_q[0]) + PRE_ONE)
        else $error("interval unit prescaler miscounts");

    coarse_force_a: assert property (
        crs_ovr_q[FORCE_BIT] |=> COARSE_CODE_O == $past(crs_ovr_q[AMP_CODE_W-1:0])
            && !COARSE_UPDATE_O)
        else $error("forced coarse code not applied");

    fine_force_a: assert property (
        fin_ovr_q[FORCE_BIT] |=> FINE_CODE_O == $past(fin_ovr_q[AMP_CODE_W-1:0])
            && !FINE_UPDATE_O)
        else $error("forced fine code not applied");

    amp_period_a: assert property (
        (upd[1] || upd[2]) |-> (upd[1] ? gap_q[1] : gap_q[2])
            == 32'(amp_per_q) * 32'(UNIT_CYC_P) - 32'h00000001)
        else $error("amplifier refresh interval wrong");

    amp_zero_a: assert property (
        (amp_per_q == PER_ZERO) |=> !COARSE_UPDATE_O && !FINE_UPDATE_O)
        else $error("amplifier updated with zero period");

    osc_split_a: assert property (
        osc_ovr_q[FORCE_BIT] |=> OSC_CODE_O.range_sel == $past(osc_ovr_q[7:6])
            && OSC_CODE_O.step == $past(osc_ovr_q[5:0]))
        else $error("oscillator range and step split wrong");

    fresh_start_a: assert property (
        $fell(osc_ovr_q[FORCE_BIT]) |-> pre_q[0] == PRE_ZERO && cnt_q[0] == PER_ZERO)
        else $error("interval not fresh after force cleared");

    reserved_zero_a: assert property (
        (AVS_READ_I && wait_q && (hit_osc_ovr || hit_crs_ovr || hit_fin_ovr))
            |=> AVS_READDATA_O[14:8] == 7'h00 && !AVS_WAITREQUEST_O)
        else $error("reserved override bits not zero");

    // Bus handshake: exactly one wait cycle, then waitrequest returns high
    ack_once_a: assert property (
        !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
        else $error("waitrequest low for more than one cycle");

    ack_next_a: assert property (
        ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O) |=> !AVS_WAITREQUEST_O)
        else $error("request not acknowledged after one wait cycle");

    idle_wait_a: assert property (
        !(AVS_READ_I || AVS_WRITE_I) |=> AVS_WAITREQUEST_O)
        else $error("waitrequest low without a request");

    // Registers are 16 bits wide; the upper half of the read word is always zero
    rdata_upper_a: assert property (
        AVS_READDATA_O[DATA_W-1:REG_W] == 16'h0000)
        else $error("upper read data not zero");

    osc_wr_a: assert property (
        (wr_acc && hit_osc_ovr) |=> osc_ovr_q == $past(osc_ovr_d))
        else $error("oscillator override write lost");

    // A period write lands and restarts the oscillator interval
    osc_per_wr_a: assert property (
        (wr_acc && hit_osc_per) |=> osc_per_q == $past(osc_per_d)
            && pre_q[0] == PRE_ZERO && cnt_q[0] == PER_ZERO)
        else $error("oscillator period write did not restart timer");

    osc_hold_a: assert property (
        osc_ovr_q[FORCE_BIT] |-> !upd[0])
        else $error("oscillator refreshed while forced");

    amp_hold_a: assert property (
        (amp_per_q == PER_ZERO) |-> !upd[1] && !upd[2])
        else $error("amplifier refresh with zero period");

    // Coarse and fine in step must refresh in the same cycle
    amp_pair_a: assert property (
        (!force_en[1] && !force_en[2] && cnt_q[1] == cnt_q[2] && pre_q[1] == pre_q[2])
            |-> upd[1] == upd[2])
        else $error("coarse and fine refresh out of step");

    crs_wrap_a: assert property (
        (!hold[1] && pre_q[1] == PRE_MAX) |=> pre_q[1] == PRE_ZERO)
        else $error("coarse unit prescaler does not wrap");

    // Each refresh applies the automatic code and pulses the update output
    osc_auto_a: assert property (
        upd[0] |=> OSC_CODE_O == $past(OSC_AUTO_CODE_I) && OSC_UPDATE_O)
        else $error("oscillator refresh did not apply automatic code");

    crs_auto_a: assert property (
        upd[1] |=> COARSE_CODE_O == $past(COARSE_AUTO_CODE_I) && COARSE_UPDATE_O)
        else $error("coarse refresh did not apply automatic code");

    fin_auto_a: assert property (
        upd[2] |=> FINE_CODE_O == $past(FINE_AUTO_CODE_I) && FINE_UPDATE_O)
        else $error("fine refresh did not apply automatic code");

    fine_fresh_a: assert property (
        $fell(fin_ovr_q[FORCE_BIT]) |-> pre_q[2] == PRE_ZERO && cnt_q[2] == PER_ZERO)
        else $error("fine interval not fresh after force cleared");

    osc_refresh_c: cover property (OSC_UPDATE_O);
    zero_hold_c: cover property (osc_per_q == PER_ZERO && amp_per_q == PER_ZERO);
    amp_refresh_c: cover property (COARSE_UPDATE_O && FINE_UPDATE_O);
    force_release_c: cover property ($fell(crs_ovr_q[FORCE_BIT]) ##[1:1000] COARSE_UPDATE_O);
    read_ack_c: cover property (AVS_READ_I && !AVS_WAITREQUEST_O);

endmodule

// ==== tb/gdc_gain_ctrl_test.sv ====
`timescale 1ns/1ps
module gdc_gain_ctrl_test;
    import gdc_pkg::*;
    // Short interval unit keeps every refresh period a handful of cycles
    localparam int UNIT = 4;
    logic clk, rst, rd_en, wr_en, wait_req, osc_upd, crs_upd, fin_upd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [3:0] be;
    gdc_osc_code_t osc_auto, osc_code;
    logic [AMP_CODE_W-1:0] crs_auto, fin_auto, crs_code, fin_code;
    wire [2:0] upd = {fin_upd, crs_upd, osc_upd};
    int num_errors = 0;
    int n_checks = 0;
    logic [31:0] r;
    int n;

    gdc_gain_ctrl #(.UNIT_CYC_P(UNIT)) u_gdc_gain_ctrl (
        .CLK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_en),
        .AVS_WRITE_I(wr_en), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
        .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_req),
        .OSC_AUTO_CODE_I(osc_auto), .COARSE_AUTO_CODE_I(crs_auto),
        .FINE_AUTO_CODE_I(fin_auto), .OSC_CODE_O(osc_code), .COARSE_CODE_O(crs_code),
        .FINE_CODE_O(fin_code), .OSC_UPDATE_O(osc_upd), .COARSE_UPDATE_O(crs_upd),
        .FINE_UPDATE_O(fin_upd));

    // Free-running 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Verdict and end of run
    task automatic conclude;
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Case equality so an unknown never passes
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One bus access; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [IDX_W-1:0] idx, input logic [15:0] wd,
                       input logic [3:0] ben, output logic [31:0] rd);
        int k;
        @(posedge clk);
        addr <= {idx, 2'b00};
        wdata <= {16'h0000, wd};
        be <= ben;
        wr_en <= wr;
        rd_en <= !wr;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wait_req !== 1'b0 && k < 50);
        if (k >= 50) begin
            num_errors++;
            conclude();
        end
        rd = rdata;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
    endtask

    task automatic wr(input logic [IDX_W-1:0] idx, input logic [15:0] d);
        logic [31:0] dummy;
        bus(1'b1, idx, d, 4'hf, dummy);
    endtask

    task automatic rdchk(input logic [IDX_W-1:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, idx, 16'h0000, 4'hf, d);
        chk(d, exp);
    endtask

    // Counts edges until a selected update pulse is seen, or the limit runs out
    task automatic wait_pulse(input logic [2:0] mask, input int lim, output int k);
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while ((upd & mask) === 3'b000 && k < lim);
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        rd_en = 1'b0;
        wr_en = 1'b0;
        addr = '0;
        wdata = '0;
        be = 4'h0;
        osc_auto = 8'h9a;
        crs_auto = 6'h0b;
        fin_auto = 6'h15;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rdchk(IDX_OSC_OVR, 32'h00000000);
        rdchk(IDX_OSC_PER, 32'h000001f4);
        rdchk(IDX_CRS_OVR, 32'h00000000);
        rdchk(IDX_FIN_OVR, 32'h00000000);
        rdchk(IDX_AMP_PER, 32'h000001f4);
        // Upper lane only: low byte of the period must survive
        bus(1'b1, IDX_OSC_PER, 16'h1234, 4'h2, r);
        rdchk(IDX_OSC_PER, 32'h000012f4);
        wr(7'h60, 16'hffff);
        rdchk(7'h60, 32'h00000000);
        // Oscillator refresh spacing and sampled code
        wr(IDX_OSC_PER, 16'h0002);
        wait_pulse(3'b001, 40, n);
        wait_pulse(3'b001, 40, n);
        chk(32'(n), 32'(2 * UNIT));
        chk({24'h000000, osc_code}, 32'h0000009a);
        // Shared amplifier period: both refresh together
        wr(IDX_AMP_PER, 16'h0003);
        wait_pulse(3'b010, 60, n);
        chk({31'h0, fin_upd}, 32'h00000001);
        chk({26'h0, crs_code}, 32'h0000000b);
        chk({26'h0, fin_code}, 32'h00000015);
        crs_auto <= 6'h21;
        wait_pulse(3'b010, 60, n);
        chk(32'(n), 32'(3 * UNIT));
        chk({26'h0, crs_code}, 32'h00000021);
        // Reserved bits dropped on write
        wr(IDX_OSC_OVR, 16'hffff);
        rdchk(IDX_OSC_OVR, 32'h000080ff);
        wr(IDX_CRS_OVR, 16'hffff);
        rdchk(IDX_CRS_OVR, 32'h0000803f);
        wr(IDX_FIN_OVR, 16'hffff);
        rdchk(IDX_FIN_OVR, 32'h0000803f);
        // Forced codes applied, automatic refresh suspended
        wr(IDX_OSC_OVR, 16'h8085);
        wr(IDX_CRS_OVR, 16'h8016);
        wr(IDX_FIN_OVR, 16'h8007);
        wait_pulse(3'b111, 40, n);
        chk(32'(n), 32'd40);
        chk({24'h000000, osc_code}, 32'h00000085);
        chk({30'h0, osc_code.range_sel}, 32'h00000002);
        chk({26'h0, osc_code.step}, 32'h00000005);
        chk({26'h0, crs_code}, 32'h00000016);
        chk({26'h0, fin_code}, 32'h00000007);
        rdchk(IDX_OSC_STAT, 32'h00000185);
        rdchk(IDX_AMP_STAT, 32'h00000716);
        // Release restarts a full interval
        wr(IDX_OSC_OVR, 16'h0000);
        wait_pulse(3'b001, 40, n);
        chk(32'(n >= 2 * UNIT && n <= 2 * UNIT + 2), 32'h00000001);
        chk({24'h000000, osc_code}, 32'h0000009a);
        wait_pulse(3'b001, 40, n);
        chk(32'(n), 32'(2 * UNIT));
        wr(IDX_CRS_OVR, 16'h0000);
        wr(IDX_FIN_OVR, 16'h0000);
        // Zero periods stop every refresh
        wr(IDX_OSC_PER, 16'h0000);
        wr(IDX_AMP_PER, 16'h0000);
        wait_pulse(3'b111, 60, n);
        chk(32'(n), 32'd60);
        conclude();
    end
endmodule
